// [include/pcs_defs.vh]
// constants for the position command streamer batch selection block
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH
// command classes presented by the decoder
`define PCS_CLS_OTHER 4'h0
`define PCS_CLS_BB_START 4'h1
`define PCS_CLS_BB_END 4'h2
`define PCS_CLS_COND_END 4'h3
`define PCS_CLS_MI 4'h4
`define PCS_CLS_MI_EXCL 4'h5
`define PCS_CLS_STATE 4'h6
`define PCS_CLS_SEMA 4'h7
// batch start level field
`define PCS_LVL_CHAIN 2'h0
`define PCS_LVL_NEXT 2'h1
// register offsets (byte addresses)
`define PCS_OFF_CTRL 8'h00
`define PCS_OFF_STATUS 8'h04
`define PCS_OFF_COUNT 8'h08
`define PCS_OFF_IMAGE 8'h0C
// control reset value: bit0 enable
`define PCS_CTRL_RST 32'h0000_0001
// saved ring-context image layout
`define PCS_IMG_HDR_DW 8'h02
`define PCS_IMG_ENTRIES 8'h0E
`define PCS_IMG_ENTRY_DW 8'h02
`define PCS_IMG_PAD_DW 8'h30
`define PCS_IMG_TOTAL_DW 8'h4E
`define PCS_NOOP_DW 32'h0000_0000
`define PCS_LRI_DW 32'h1100_001B
`endif

// [logic/pcs_batch_select.v]
// batch selection and command filter of the position command streamer
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.vh"
// Function
// R01: saved context image: noop, load-immediate header, two-dword entries, 48-dword noop pad.
// R02: batch start with execute flag makes its commands executed here.
// R03: execute state inherited by chained and deeper batches regardless of header.
// R04: execute state clears only when its level ends and returns outward.
// R05: render streamer treats execute-flagged batch start as no-op.
// R06: all miscellaneous commands supported except the excluded set.
// R07: software never sends excluded commands to this streamer.
// R08: semaphores pass both ways; render side never relays ours onward.
// R09: unsupported 3D state commands are dropped silently as no-ops.
// R10: ring is walked without execution, looking only for flagged batch starts.
// R11: parse flag makes a batch traversed, not executed, seeking execute flags.
// R12: parse flag inherited by chained batches only, not deeper ones.
// R13: deeper batches from a parse-only batch skipped unless call carries parse flag.
// R14: software sets parse flag on calls whose deeper batch must be searched.
// R15: parse-only batch ends at batch end or satisfied conditional end.
// R16: both flags set means execute wins.
// R17: render streamer ignores the parse flag.
// R18: separate flag state for ring and three levels, restored on return.
// R19: nothing directly in the ring is executed here.
module pcs_batch_select (
  input wire aclk,
  input wire aresetn,
  // decoded command stream
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [3:0] cmd_class,
  input wire execute_for_position_flag,
  input wire parse_only_flag,
  input wire [1:0] cmd_level,
  input wire cond_met,
  input wire state_supported,
  input wire [31:0] cmd_dword,
  // dispositions
  output reg exec_valid,
  output reg [31:0] exec_dword,
  output reg [3:0] exec_class,
  output reg discard_pulse,
  output reg skip_pulse,
  output reg fetch_batch,
  output reg [1:0] fetch_level,
  output reg batch_return,
  // render streamer view of the same stream
  output reg render_noop,
  output reg render_exec_start,
  // semaphores
  input wire sema_from_render,
  output reg sema_to_render,
  output reg sema_relay_allowed,
  output reg sema_received,
  // AXI4-Lite
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_RING = 2'h0;
  localparam ST_L1 = 2'h1;
  localparam ST_L2 = 2'h2;
  localparam ST_L3 = 2'h3;

  reg [1:0] level_reg;
  reg [3:0] exec_lvl_reg;
  reg [3:0] parse_lvl_reg;
  reg [3:0] skip_lvl_reg;
  reg [31:0] ctrl_reg;
  reg [15:0] exec_count_reg;
  reg [15:0] discard_count_reg;
  reg [7:0] img_idx_reg;

  wire enabled;
  wire cur_exec;
  wire cur_parse;
  wire cur_skip;
  wire take;
  wire is_start;
  wire is_end;
  wire deeper;
  wire [1:0] up_level;

  assign enabled = ctrl_reg[0];
  assign cur_exec = exec_lvl_reg[level_reg];
  assign cur_parse = parse_lvl_reg[level_reg];
  assign cur_skip = skip_lvl_reg[level_reg];
  assign cmd_ready = enabled;
  assign take = cmd_valid & enabled;
  assign is_start = cmd_class == `PCS_CLS_BB_START;
  assign is_end = (cmd_class == `PCS_CLS_BB_END) |
                  ((cmd_class == `PCS_CLS_COND_END) & cond_met); // R04 R15
  assign deeper = (cmd_level == `PCS_LVL_NEXT) | (level_reg == ST_RING);
  assign up_level = level_reg + 2'h1;

  // stream disposition and nesting state
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= ST_RING;
      exec_lvl_reg <= 4'h0;
      parse_lvl_reg <= 4'h0;
      skip_lvl_reg <= 4'h0;
      exec_valid <= 1'b0;
      exec_dword <= 32'h0000_0000;
      exec_class <= 4'h0;
      discard_pulse <= 1'b0;
      skip_pulse <= 1'b0;
      fetch_batch <= 1'b0;
      fetch_level <= 2'h0;
      batch_return <= 1'b0;
      render_noop <= 1'b0;
      render_exec_start <= 1'b0;
      exec_count_reg <= 16'h0000;
      discard_count_reg <= 16'h0000;
    end else begin
      exec_valid <= 1'b0;
      discard_pulse <= 1'b0;
      skip_pulse <= 1'b0;
      fetch_batch <= 1'b0;
      batch_return <= 1'b0;
      render_noop <= 1'b0;
      render_exec_start <= 1'b0;
      if (take && is_start) begin
        // render side: execute flag makes a no-op, parse flag has no effect
        render_noop <= execute_for_position_flag; // R05
        render_exec_start <= ~execute_for_position_flag; // R17
      end
      if (take) begin
        case (1'b1)
          cur_skip: begin
            // an unsearched batch: only its own end matters
            skip_pulse <= 1'b1; // R13
            if (is_end && level_reg != ST_RING) begin
              skip_lvl_reg[level_reg] <= 1'b0;
              exec_lvl_reg[level_reg] <= 1'b0;
              parse_lvl_reg[level_reg] <= 1'b0;
              level_reg <= level_reg - 2'h1;
              batch_return <= 1'b1;
            end
          end
          is_start: begin
            fetch_batch <= 1'b1;
            if (deeper && level_reg != ST_L3) begin
              fetch_level <= up_level;
              level_reg <= up_level;
              // outer state stays in its own slot for the return
              exec_lvl_reg[up_level] <= cur_exec | execute_for_position_flag; // R02 R03 R18
              parse_lvl_reg[up_level] <= ~cur_exec & ~execute_for_position_flag &
                                         parse_only_flag; // R12 R16
              skip_lvl_reg[up_level] <= ~cur_exec & ~execute_for_position_flag &
                                        ~parse_only_flag; // R13 R10
            end else begin
              fetch_level <= level_reg;
              exec_lvl_reg[level_reg] <= cur_exec | execute_for_position_flag; // R03
              parse_lvl_reg[level_reg] <= ~(cur_exec | execute_for_position_flag) &
                                          (cur_parse | parse_only_flag); // R12 R16
              skip_lvl_reg[level_reg] <= ~(cur_exec | execute_for_position_flag) &
                                         ~(cur_parse | parse_only_flag);
            end
          end
          is_end: begin
            if (level_reg != ST_RING) begin
              exec_lvl_reg[level_reg] <= 1'b0; // R04
              parse_lvl_reg[level_reg] <= 1'b0; // R15
              level_reg <= level_reg - 2'h1; // R18
              batch_return <= 1'b1;
            end
          end
          (cur_exec && level_reg != ST_RING): begin // R19
            if (cmd_class == `PCS_CLS_MI_EXCL ||
                (cmd_class == `PCS_CLS_STATE && !state_supported)) begin
              discard_pulse <= 1'b1; // R06 R09
              discard_count_reg <= discard_count_reg + 16'h0001;
            end else begin
              exec_valid <= 1'b1;
              exec_dword <= cmd_dword;
              exec_class <= cmd_class;
              exec_count_reg <= exec_count_reg + 16'h0001;
            end
          end
          default: skip_pulse <= 1'b1; // R10 R11
        endcase
      end
    end
  end

  // semaphore exchange
  always @(posedge aclk) begin
    if (!aresetn) begin
      sema_to_render <= 1'b0;
      sema_received <= 1'b0;
      sema_relay_allowed <= 1'b0;
    end else begin
      sema_to_render <= take & cur_exec & (level_reg != ST_RING) &
                        (cmd_class == `PCS_CLS_SEMA); // R08
      sema_received <= sema_from_render; // R08
      sema_relay_allowed <= 1'b0; // R08
    end
  end

  // saved context image word by index
  function [31:0] img_word;
    input [7:0] idx;
    begin
      if (idx == 8'h00)
        img_word = `PCS_NOOP_DW; // R01
      else if (idx == 8'h01)
        img_word = `PCS_LRI_DW; // R01
      else if (idx < `PCS_IMG_HDR_DW + `PCS_IMG_ENTRIES * `PCS_IMG_ENTRY_DW)
        img_word = {24'h00_0000, idx}; // R01
      else
        img_word = `PCS_NOOP_DW; // R01
    end
  endfunction

  // AXI4-Lite slave
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  integer i;
  wire do_write;

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_reg <= `PCS_CTRL_RST;
      img_idx_reg <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        if (aw_addr_reg == `PCS_OFF_CTRL) begin
          for (i = 0; i < 4; i = i + 1)
            if (w_strb_reg[i])
              ctrl_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
        end else if (aw_addr_reg == `PCS_OFF_IMAGE) begin
          if (w_strb_reg[0])
            img_idx_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg != `PCS_OFF_STATUS && aw_addr_reg != `PCS_OFF_COUNT) begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `PCS_OFF_CTRL: s_axi_rdata <= ctrl_reg;
        `PCS_OFF_STATUS: s_axi_rdata <= {18'h0_0000, level_reg, skip_lvl_reg,
                                         parse_lvl_reg, exec_lvl_reg};
        `PCS_OFF_COUNT: s_axi_rdata <= {discard_count_reg, exec_count_reg};
        `PCS_OFF_IMAGE: s_axi_rdata <= (img_idx_reg < `PCS_IMG_TOTAL_DW) ?
                                       img_word(img_idx_reg) : 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb/pcs_chk.sv]
// port assertions for the batch selection block
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.vh"
module pcs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [3:0] cmd_class,
  input wire logic execute_for_position_flag,
  input wire logic state_supported,
  input wire logic [31:0] cmd_dword,
  input wire logic exec_valid,
  input wire logic [31:0] exec_dword,
  input wire logic [3:0] exec_class,
  input wire logic sema_to_render,
  input wire logic render_noop,
  input wire logic render_exec_start,
  input wire logic sema_from_render,
  input wire logic sema_relay_allowed,
  input wire logic sema_received
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_start;
    s_take ##0 cmd_class == `PCS_CLS_BB_START;
  endsequence
  property p_data;
    logic [31:0] d;
    (s_take, d = cmd_dword) |=> !exec_valid || exec_dword == d;
  endproperty
  AST_EXEC_DATA: assert property (p_data) else $error("exec word");
  property p_class;
    logic [3:0] c;
    (s_take, c = cmd_class) |=> !exec_valid || exec_class == c;
  endproperty
  AST_EXEC_CLASS: assert property (p_class) else $error("exec class");
  AST_SEMA_TX: assert property (
    s_take ##0 cmd_class == `PCS_CLS_SEMA |=> sema_to_render == exec_valid)
    else $error("sema tx");
  AST_RENDER_NOOP: assert property (
    s_start ##0 execute_for_position_flag |=> render_noop && !render_exec_start)
    else $error("render noop");
  // the parse flag is left out on purpose: the render side must not see it
  AST_RENDER_PARSE: assert property (
    s_start ##0 !execute_for_position_flag |=> render_exec_start && !render_noop)
    else $error("render start");
  AST_NO_RELAY: assert property (!sema_relay_allowed) else $error("relay");
  AST_SEMA_RX: assert property (
    $rose(sema_from_render) |=> sema_received) else $error("sema rx");
  AST_EXCL: assert property (
    s_take ##0 cmd_class == `PCS_CLS_MI_EXCL |=> !exec_valid) else $error("excluded");
  AST_STATE: assert property (
    s_take ##0 cmd_class == `PCS_CLS_STATE && !state_supported |=> !exec_valid)
    else $error("state");
  AST_START_NOEXEC: assert property (s_start |=> !exec_valid) else $error("start");
endmodule
bind pcs_batch_select pcs_chk u_chk (
  .aclk, .aresetn, .cmd_valid, .cmd_ready, .cmd_class, .execute_for_position_flag,
  .state_supported, .cmd_dword, .exec_valid, .exec_dword, .exec_class, .sema_to_render,
  .render_noop,
  .render_exec_start, .sema_from_render, .sema_relay_allowed, .sema_received);
`default_nettype wire

// [tb/pcs_render_model.sv]
// render streamer stand-in answering semaphore signals
`timescale 1ns/10ps
`default_nettype none
module pcs_render_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sema_to_render,
  output var logic sema_from_render
);
  logic slow;
  logic [2:0] wait_cnt;
  // answers alternate prompt and slow; what it receives is never passed on
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow <= 1'b0;
      wait_cnt <= 3'h0;
      sema_from_render <= 1'b0;
    end else begin
      sema_from_render <= wait_cnt == 3'h1;
      if (sema_to_render) begin
        wait_cnt <= slow ? 3'h6 : 3'h1;
        slow <= ~slow;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the batch selection block
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defs.vh"
module testbench;
  logic aclk = 0, aresetn = 0, cmd_valid = 0, execute_for_position_flag = 0;
  logic parse_only_flag = 0, cond_met = 0, state_supported = 0, s_axi_awvalid = 0;
  logic s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] cmd_class = 0;
  logic [1:0] cmd_level = 0;
  logic [31:0] cmd_dword = 0, s_axi_wdata = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  wire cmd_ready, exec_valid, discard_pulse, skip_pulse, fetch_batch, batch_return;
  wire sema_to_render, sema_from_render, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_rresp, s_axi_bresp, fetch_level;
  wire [31:0] exec_dword, s_axi_rdata;
  integer seed = 89;
  int mismatches = 0, checked = 0, cycles = 0;
  int fetches = 0, returns = 0, skips = 0, semas = 0;
  logic [33:0] exp_q[$];
  // entry: class, flags {exec, parse, cond/supported}, {level, exec, discard}
  localparam logic [11:0] PROG [36] = '{12'h400, 12'h144, 12'h402, 12'h702, 12'h601,
    12'h612, 12'h501, 12'h104, 12'h402, 12'h100, 12'h402, 12'h200, 12'h402, 12'h310,
    12'h400, 12'h124, 12'h400, 12'h104, 12'h400, 12'h200, 12'h100, 12'h164, 12'h402,
    12'h200, 12'h300, 12'h400, 12'h200, 12'h400, 12'h144, 12'h104, 12'h104, 12'h104,
    12'h402, 12'h200, 12'h200, 12'h200};
  // entry words carry their own index, so a wrong slot shows up
  localparam logic [7:0] IMG_IDX [4] = '{8'h01, 8'h1D, 8'h4D, 8'h4E};
  localparam logic [31:0] IMG_VAL [4] = '{`PCS_LRI_DW, 32'h0000_001D, `PCS_NOOP_DW,
    32'h0000_0000};
  pcs_batch_select DUT (
    .aclk, .aresetn, .cmd_valid, .cmd_ready, .cmd_class, .execute_for_position_flag,
    .parse_only_flag, .cmd_level, .cond_met, .state_supported, .cmd_dword, .exec_valid,
    .exec_dword, .exec_class(), .discard_pulse, .skip_pulse, .fetch_batch, .fetch_level,
    .batch_return, .render_noop(), .render_exec_start(), .sema_from_render,
    .sema_to_render, .sema_relay_allowed(), .sema_received(), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  pcs_render_model u_render (.aclk, .aresetn, .sema_to_render, .sema_from_render);
  always #4 aclk = ~aclk;
  task final_report;
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ha, hw, ta, tw;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {ha, hw} = 2'h3;
    while (ha || hw) begin
      @(negedge aclk);
      ta = ha && s_axi_awready;
      tw = hw && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      {ha, hw} = {ha && !ta, hw && !tw};
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    chk("bresp", {32'h0000_0000, r}, {32'h0000_0000, s_axi_bresp});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // values are taken at the negedge before the edge that ends the transfer
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk("read", {r, d}, {s_axi_rresp, s_axi_rdata});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic cmd(input logic [11:0] t);
    logic [31:0] v;
    v = $random(seed);
    @(posedge aclk);
    {cmd_valid, cmd_class, cmd_level, cmd_dword} <= {1'b1, t[11:8], t[3:2], v};
    {execute_for_position_flag, parse_only_flag, cond_met, state_supported} <= {t[6:4], t[4]};
    exp_q.push_back({t[1:0], t[1] ? v : 32'h0000_0000});
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (aresetn && fetch_batch) fetches++;
    if (aresetn && batch_return) returns++;
    if (aresetn && skip_pulse) skips++;
    if (aresetn && sema_to_render) semas++;
    if (aresetn && (exec_valid || discard_pulse || skip_pulse || fetch_batch || batch_return))
      chk("disposition", exp_q.size() ? exp_q.pop_front() : '1,
        {exec_valid, discard_pulse, exec_valid ? exec_dword : 32'h0000_0000});
    if (cycles == 5000) begin
      mismatches++;
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PCS_OFF_CTRL, `PCS_CTRL_RST, 2'h0);
    rd(8'h10, 32'h0000_0000, 2'h2);
    wr(8'h10, 32'h0000_0000, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(`PCS_OFF_IMAGE, {24'h00_0000, IMG_IDX[i]}, 2'h0);
      rd(`PCS_OFF_IMAGE, IMG_VAL[i], 2'h0);
    end
    wr(`PCS_OFF_CTRL, 32'h0000_0000, 2'h0);
    @(negedge aclk);
    chk("cmd_ready", 34'h0, {33'h0, cmd_ready});
    wr(`PCS_OFF_CTRL, 32'h0000_0001, 2'h0);
    // one excluded command goes in anyway, to show that it is dropped and never run
    foreach (PROG[i]) cmd(PROG[i]);
    @(posedge aclk);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(`PCS_OFF_COUNT, 32'h0002_0008, 2'h0);
    chk("fetches", 34'h0_0000_000B, 34'(fetches));
    chk("returns", 34'h0_0000_0008, 34'(returns));
    chk("skips", 34'h0_0000_0008, 34'(skips));
    chk("semas", 34'h0_0000_0001, 34'(semas));
    chk("fetch_level", 34'h0_0000_0003, {32'h0000_0000, fetch_level});
    chk("pending", 34'h0, 34'(exp_q.size()));
    final_report;
  end
endmodule
`default_nettype wire
